// File: shared/fmcc_pkg.sv
/*
 * Package for the field memory configuration block: sub addresses,
 * field positions, reset values, picture limits and carrier structs.
 * Assumes an upstream serial front end that turns bus transfers into
 * sub-address byte writes and reads.
 */
package fmcc_pkg;

	localparam logic [7:0] FMCC_SUB_OPERATION = 8'h53;
	localparam logic [7:0] FMCC_SUB_SLAVE     = 8'h57;
	localparam logic [7:0] FMCC_SUB_MASTER    = 8'h58;

	// Bit positions inside the channel setup bytes
	localparam int FMCC_BIT_A_ONLY = 0;
	localparam int FMCC_BIT_ORG    = 1;
	localparam int FMCC_BIT_RD     = 2;
	localparam int FMCC_BIT_WR     = 3;
	// Pending flag in the operation byte read-back
	localparam int FMCC_BIT_PEND   = 7;

	localparam logic [1:0] FMCC_OP_SCAN_RATE = 2'h0;
	localparam logic [1:0] FMCC_OP_SPLIT     = 2'h1;
	localparam logic [1:0] FMCC_OP_MULTI     = 2'h2;

	localparam logic [1:0] FMCC_OP_RESET        = 2'h0;
	localparam logic       FMCC_A_ONLY_RESET    = 1'h0;
	localparam logic       FMCC_ORG_RESET       = 1'h1;
	localparam logic       FMCC_RD_RESET        = 1'h0;
	localparam logic       FMCC_WR_RESET        = 1'h0;

	localparam logic [1:0] FMCC_FIELDS_NONE  = 2'h0;
	localparam logic [1:0] FMCC_FIELDS_ONE   = 2'h1;
	localparam logic [1:0] FMCC_FIELDS_TWO   = 2'h2;
	localparam logic [1:0] FMCC_FIELDS_THREE = 2'h3;

	localparam logic [9:0] FMCC_PX_0   = 10'h000;
	localparam logic [9:0] FMCC_PX_256 = 10'h100;
	localparam logic [9:0] FMCC_PX_512 = 10'h200;
	localparam logic [9:0] FMCC_PX_768 = 10'h300;
	localparam logic [9:0] FMCC_LN_0   = 10'h000;
	localparam logic [9:0] FMCC_LN_104 = 10'h068;
	localparam logic [9:0] FMCC_LN_170 = 10'h0aa;
	localparam logic [9:0] FMCC_LN_256 = 10'h100;
	localparam logic [9:0] FMCC_LN_288 = 10'h120;
	localparam logic [9:0] FMCC_LN_341 = 10'h155;
	localparam logic [9:0] FMCC_LN_512 = 10'h200;

	typedef struct packed {
		logic wr_sel;
		logic rd_sel;
		logic org;
		logic a_only;
	} fmcc_chan_type;

	typedef struct packed {
		logic       scan_rate_conversion_operation;
		logic       split_screen_operation;
		logic       multi_picture_operation;
		logic [1:0] master_fields;
		logic [1:0] slave_fields;
		logic       master_a_field_only_write;
		logic       slave_a_field_only_write;
		logic       master_read_single_area;
		logic       slave_read_insert_layout;
		logic       master_width_768;
		logic       slave_width_768;
		logic       slave_write_dual_layout;
		logic       vector_upconversion_allowed;
		logic       double_window_config;
		logic [9:0] master_max_pixels;
		logic [9:0] master_max_lines;
		logic [9:0] slave_max_pixels;
		logic [9:0] slave_max_lines;
	} fmcc_decode_type;

endpackage : fmcc_pkg

// File: logic/fmcc_config.sv
/*
 * Field memory configuration register bank for a dual-channel display
 * processor: holds the operation selector and per-channel memory
 * setup bytes, applies them at field boundaries and decodes the layout.
 * Assumes sub-address write/read strobes from a serial front end and
 * one-cycle field start pulses from each channel's input timing.
 */
`timescale 1ns/1ps

// Contract
// - Selector 00 scan-rate, 01 split-screen, 10 multi-picture; resets to 00.
// - Split or multi with both organization bits: 512x256 or 768x170 limit.
// - In multi-picture, A-field-only bit set stores only A fields.
// - Master setup at 58h, slave at 57h; A-field-only bits reset 0.
// - Organization 1 keeps three fields in scan-rate, two otherwise.
// - Organization 0: no slave in scan-rate if master org 1, else one field.
// - Scan-rate master read bit 1 reads one area, 0 reads both.
// - Scan-rate slave read bit 1 uses insert layout, 0 split layout.
// - Split or multi master write bit selects 512 or 768 pixels.
// - Slave write bit: insert or dual layout; or 512 or 768 pixels.
// - Split-screen offers only field-based up-conversion, no vector modes.
module fmcc_config (
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic [7:0]               sub_addr_i,
	input  wire logic                     wr_en_i,
	input  wire logic                     rd_en_i,
	input  wire logic [7:0]               wdata_i,
	input  wire logic                     master_field_start_i,
	input  wire logic                     slave_field_start_i,
	output logic [7:0]                    rdata_o,
	output fmcc_pkg::fmcc_decode_type     cfg_o
);

	typedef struct packed {
		logic [1:0]                op_shadow;
		logic [1:0]                op_active;
		fmcc_pkg::fmcc_chan_type   m_shadow;
		fmcc_pkg::fmcc_chan_type   m_active;
		fmcc_pkg::fmcc_chan_type   s_shadow;
		fmcc_pkg::fmcc_chan_type   s_active;
		fmcc_pkg::fmcc_decode_type dec;
		logic [7:0]                rdata;
	} fmcc_state_type;

	fmcc_state_type state_q;
	fmcc_state_type state_d;

	function automatic fmcc_pkg::fmcc_chan_type chan_from_byte(
		input logic [7:0] b
	);
		fmcc_pkg::fmcc_chan_type c;
		c.a_only = b[fmcc_pkg::FMCC_BIT_A_ONLY];
		c.org    = b[fmcc_pkg::FMCC_BIT_ORG];
		c.rd_sel = b[fmcc_pkg::FMCC_BIT_RD];
		c.wr_sel = b[fmcc_pkg::FMCC_BIT_WR];
		return c;
	endfunction : chan_from_byte

	function automatic logic [7:0] chan_to_byte(
		input fmcc_pkg::fmcc_chan_type c
	);
		logic [7:0] b;
		b = 8'h00;
		b[fmcc_pkg::FMCC_BIT_A_ONLY] = c.a_only;
		b[fmcc_pkg::FMCC_BIT_ORG]    = c.org;
		b[fmcc_pkg::FMCC_BIT_RD]     = c.rd_sel;
		b[fmcc_pkg::FMCC_BIT_WR]     = c.wr_sel;
		return b;
	endfunction : chan_to_byte

	function automatic fmcc_pkg::fmcc_decode_type decode(
		input logic [1:0]              op,
		input fmcc_pkg::fmcc_chan_type m,
		input fmcc_pkg::fmcc_chan_type s
	);
		fmcc_pkg::fmcc_decode_type d;
		logic scan;
		d = '0;
		// Reserved selector 11 falls back to scan-rate handling
		d.split_screen_operation  = (op == fmcc_pkg::FMCC_OP_SPLIT);
		d.multi_picture_operation = (op == fmcc_pkg::FMCC_OP_MULTI);
		scan = !d.split_screen_operation && !d.multi_picture_operation;
		d.scan_rate_conversion_operation = scan;
		// Field reservation per channel
		if (m.org)
			d.master_fields = scan ? fmcc_pkg::FMCC_FIELDS_THREE
			                       : fmcc_pkg::FMCC_FIELDS_TWO;
		else
			d.master_fields = fmcc_pkg::FMCC_FIELDS_ONE;
		if (s.org)
			d.slave_fields = scan ? fmcc_pkg::FMCC_FIELDS_THREE
			                      : fmcc_pkg::FMCC_FIELDS_TWO;
		else if (scan && m.org)
			d.slave_fields = fmcc_pkg::FMCC_FIELDS_NONE;
		else
			d.slave_fields = fmcc_pkg::FMCC_FIELDS_ONE;
		d.master_a_field_only_write =
			d.multi_picture_operation && m.a_only;
		d.slave_a_field_only_write =
			d.multi_picture_operation && s.a_only;
		d.master_read_single_area  = scan && m.rd_sel;
		d.slave_read_insert_layout = scan && s.rd_sel;
		d.master_width_768         = !scan && m.wr_sel;
		d.slave_width_768          = !scan && s.wr_sel;
		d.slave_write_dual_layout  = scan && s.wr_sel;
		// Vector-driven modes only in scan-rate, not in split-screen or multi-picture
		d.vector_upconversion_allowed = scan;
		d.double_window_config = !scan && m.org && s.org;
		if (scan) begin
			d.master_max_pixels = fmcc_pkg::FMCC_PX_768;
			d.master_max_lines  = s.org ? fmcc_pkg::FMCC_LN_288
			                            : fmcc_pkg::FMCC_LN_341;
			if (s.org) begin
				d.slave_max_pixels = fmcc_pkg::FMCC_PX_256;
				d.slave_max_lines  = fmcc_pkg::FMCC_LN_104;
			end else if (m.org) begin
				d.slave_max_pixels = fmcc_pkg::FMCC_PX_0;
				d.slave_max_lines  = fmcc_pkg::FMCC_LN_0;
			end else begin
				d.slave_max_pixels = fmcc_pkg::FMCC_PX_768;
				d.slave_max_lines  = fmcc_pkg::FMCC_LN_341;
			end
		end else begin
			d.master_max_pixels = m.wr_sel ? fmcc_pkg::FMCC_PX_768
			                               : fmcc_pkg::FMCC_PX_512;
			d.slave_max_pixels  = s.wr_sel ? fmcc_pkg::FMCC_PX_768
			                               : fmcc_pkg::FMCC_PX_512;
			if (m.org)
				d.master_max_lines = m.wr_sel ? fmcc_pkg::FMCC_LN_170
				                              : fmcc_pkg::FMCC_LN_256;
			else
				d.master_max_lines = m.wr_sel ? fmcc_pkg::FMCC_LN_341
				                              : fmcc_pkg::FMCC_LN_512;
			if (s.org)
				d.slave_max_lines = s.wr_sel ? fmcc_pkg::FMCC_LN_170
				                             : fmcc_pkg::FMCC_LN_256;
			else
				d.slave_max_lines = s.wr_sel ? fmcc_pkg::FMCC_LN_341
				                             : fmcc_pkg::FMCC_LN_512;
		end
		return d;
	endfunction : decode

	always_comb begin
		logic pending;
		pending = 1'b0;
		state_d = state_q;
		if (wr_en_i) begin
			case (sub_addr_i)
				fmcc_pkg::FMCC_SUB_OPERATION: begin
					state_d.op_shadow = wdata_i[1:0];
				end
				fmcc_pkg::FMCC_SUB_SLAVE: begin
					state_d.s_shadow = chan_from_byte(wdata_i);
				end
				fmcc_pkg::FMCC_SUB_MASTER: begin
					state_d.m_shadow = chan_from_byte(wdata_i);
				end
				default: begin
				end
			endcase
		end
		// A layout change mid-field would tear the stored picture
		if (master_field_start_i) begin
			state_d.op_active = state_d.op_shadow;
			state_d.m_active  = state_d.m_shadow;
		end
		if (slave_field_start_i) begin
			state_d.s_active = state_d.s_shadow;
		end
		state_d.dec = decode(state_q.op_active, state_q.m_active,
		                     state_q.s_active);
		pending = (state_q.op_shadow != state_q.op_active) ||
		          (state_q.m_shadow != state_q.m_active) ||
		          (state_q.s_shadow != state_q.s_active);
		if (rd_en_i) begin
			case (sub_addr_i)
				fmcc_pkg::FMCC_SUB_OPERATION: begin
					state_d.rdata = {6'h00, state_q.op_shadow};
					state_d.rdata[fmcc_pkg::FMCC_BIT_PEND] = pending;
				end
				fmcc_pkg::FMCC_SUB_SLAVE: begin
					state_d.rdata = chan_to_byte(state_q.s_shadow);
				end
				fmcc_pkg::FMCC_SUB_MASTER: begin
					state_d.rdata = chan_to_byte(state_q.m_shadow);
				end
				default: begin
					state_d.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= '0;
			state_q.op_shadow       <= fmcc_pkg::FMCC_OP_RESET;
			state_q.op_active       <= fmcc_pkg::FMCC_OP_RESET;
			state_q.m_shadow.org    <= fmcc_pkg::FMCC_ORG_RESET;
			state_q.m_active.org    <= fmcc_pkg::FMCC_ORG_RESET;
			state_q.s_shadow.org    <= fmcc_pkg::FMCC_ORG_RESET;
			state_q.s_active.org    <= fmcc_pkg::FMCC_ORG_RESET;
			state_q.dec.scan_rate_conversion_operation <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	assign rdata_o = state_q.rdata;
	assign cfg_o   = state_q.dec;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_selector_split_decode: assert property (
		state_q.op_active == fmcc_pkg::FMCC_OP_SPLIT |=>
		cfg_o.split_screen_operation && !cfg_o.vector_upconversion_allowed)
		else $error("split selector not decoded");
	a_a_field_only: assert property (
		state_q.op_active == fmcc_pkg::FMCC_OP_MULTI &&
		state_q.m_active.a_only |=> cfg_o.master_a_field_only_write)
		else $error("master A-field-only write not applied");
	a_master_write_lands: assert property (
		wr_en_i && sub_addr_i == fmcc_pkg::FMCC_SUB_MASTER |=>
		state_q.m_shadow.org == $past(wdata_i[fmcc_pkg::FMCC_BIT_ORG]))
		else $error("write to master setup not stored");
	a_hold_until_field: assert property (
		!master_field_start_i |=> $stable(state_q.m_active) &&
		$stable(state_q.op_active))
		else $error("master setup changed outside field boundary");
	a_field_count_three: assert property (
		state_q.s_active.org && state_q.op_active == 2'h0 |=>
		cfg_o.slave_fields == fmcc_pkg::FMCC_FIELDS_THREE)
		else $error("slave insert fields not three");
	a_no_slave_channel: assert property (
		state_q.op_active == 2'h0 && state_q.m_active.org &&
		!state_q.s_active.org |=>
		cfg_o.slave_fields == fmcc_pkg::FMCC_FIELDS_NONE)
		else $error("slave channel should be unavailable");
	a_read_single_area: assert property (
		cfg_o.master_read_single_area |->
		$past(state_q.m_active.rd_sel) && cfg_o.scan_rate_conversion_operation)
		else $error("single-area read without cause");
	a_slave_read_layout: assert property (
		state_q.op_active == 2'h0 |=>
		cfg_o.slave_read_insert_layout == $past(state_q.s_active.rd_sel))
		else $error("slave read layout mismatch");
	a_master_width: assert property (
		state_q.op_active == fmcc_pkg::FMCC_OP_SPLIT &&
		!state_q.m_active.wr_sel |=>
		cfg_o.master_max_pixels == fmcc_pkg::FMCC_PX_512)
		else $error("master line width not 512");
	a_slave_dual_write: assert property (
		state_q.op_active == 2'h0 && state_q.s_active.wr_sel |=>
		cfg_o.slave_write_dual_layout && !cfg_o.slave_width_768)
		else $error("slave dual layout write not decoded");
	a_window_limit: assert property (
		cfg_o.double_window_config && !$past(state_q.m_active.wr_sel) |->
		cfg_o.master_max_lines == fmcc_pkg::FMCC_LN_256)
		else $error("double window line limit wrong");
	a_scan_rate_decode: assert property (
		state_q.op_active == fmcc_pkg::FMCC_OP_SCAN_RATE |=>
		cfg_o.scan_rate_conversion_operation &&
		!cfg_o.split_screen_operation && !cfg_o.multi_picture_operation)
		else $error("scan-rate selector not decoded");
	a_multi_decode: assert property (
		state_q.op_active == fmcc_pkg::FMCC_OP_MULTI |=>
		cfg_o.multi_picture_operation && !cfg_o.split_screen_operation &&
		!cfg_o.scan_rate_conversion_operation)
		else $error("multi-picture selector not decoded");
	a_slave_a_field: assert property (
		state_q.op_active == fmcc_pkg::FMCC_OP_MULTI &&
		state_q.s_active.a_only |=> cfg_o.slave_a_field_only_write)
		else $error("slave A-field-only write not applied");
	a_all_fields_written: assert property (
		state_q.op_active != fmcc_pkg::FMCC_OP_MULTI |=>
		!cfg_o.master_a_field_only_write &&
		!cfg_o.slave_a_field_only_write)
		else $error("A-field-only write outside multi-picture");
	a_master_fields_two: assert property (
		(state_q.op_active == fmcc_pkg::FMCC_OP_SPLIT ||
		state_q.op_active == fmcc_pkg::FMCC_OP_MULTI) &&
		state_q.m_active.org |=>
		cfg_o.master_fields == fmcc_pkg::FMCC_FIELDS_TWO)
		else $error("master fields not two");
	a_one_field_stored: assert property (
		!state_q.m_active.org |=>
		cfg_o.master_fields == fmcc_pkg::FMCC_FIELDS_ONE)
		else $error("master fields not one");
	a_master_wide_line: assert property (
		state_q.op_active == fmcc_pkg::FMCC_OP_MULTI &&
		state_q.m_active.wr_sel |=>
		cfg_o.master_max_pixels == fmcc_pkg::FMCC_PX_768)
		else $error("master line width not 768");
	a_slave_line_width: assert property (
		state_q.op_active == fmcc_pkg::FMCC_OP_SPLIT |=>
		cfg_o.slave_max_pixels == ($past(state_q.s_active.wr_sel) ?
		fmcc_pkg::FMCC_PX_768 : fmcc_pkg::FMCC_PX_512))
		else $error("slave line width wrong");
	a_double_window_wide: assert property (
		cfg_o.double_window_config && $past(state_q.m_active.wr_sel) |->
		cfg_o.master_max_lines == fmcc_pkg::FMCC_LN_170)
		else $error("double window wide line limit wrong");
	a_slave_hold_field: assert property (
		!slave_field_start_i |=> $stable(state_q.s_active))
		else $error("slave setup changed outside field boundary");
	a_start_applies: assert property (
		master_field_start_i |=>
		state_q.m_active == state_q.m_shadow &&
		state_q.op_active == state_q.op_shadow)
		else $error("master field start did not apply setup");

endmodule : fmcc_config

// File: sim/fmcc_host.sv
/* Host model for the field memory configuration bank: byte writes and
 * reads on the sub-address strobes, plus the mode transition steps.
 * Assumes callers enter its tasks on a rising clock edge. */
`timescale 1ns/1ps
module fmcc_host (
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	output logic [7:0]      sub_addr_o,
	output logic            wr_en_o,
	output logic            rd_en_o,
	output logic [7:0]      wdata_o
);
	initial begin
		sub_addr_o = 8'h00;
		wr_en_o    = 1'b0;
		rd_en_o    = 1'b0;
		wdata_o    = 8'h00;
	end
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		sub_addr_o <= a;
		wdata_o    <= d;
		wr_en_o    <= 1'b1;
		@(posedge clk_i);
		wr_en_o    <= 1'b0;
		// Released data must not keep looking valid
		wdata_o    <= ~d;
		@(posedge clk_i);
	endtask : put
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		sub_addr_o <= a;
		rd_en_o    <= 1'b1;
		@(posedge clk_i);
		rd_en_o    <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask : get
	// Steps as {selector, master byte, slave byte}; up-conversion set apart
	function automatic logic [23:0] step(input int i);
		case (i)
			0: return 24'h000202;
			1: return 24'h000602;
			2: return 24'h00040a;
			3: return 24'h00040e;
			4: return 24'h010802;
			5: return 24'h010802;
			default: return 24'h010202;
		endcase
	endfunction : step
endmodule : fmcc_host

// File: sim/test_fmcc_config.sv
/* Self-checking bench for fmcc_config: a model of shadow and active
 * setup predicts the decoded layout after every field start.
 * Assumes the host model fmcc_host drives the register strobes. */
`timescale 1ns/1ps
module test_fmcc_config;
	logic                      clk_i = 1'b0;
	logic                      rst_n_i = 1'b0;
	logic                      mfs = 1'b0;
	logic                      sfs = 1'b0;
	logic [7:0]                sub_addr, wdata, rdata, rd;
	logic                      wr_en, rd_en;
	fmcc_pkg::fmcc_decode_type cfg;
	logic [7:0]                sh [3];
	logic [7:0]                act [3];
	int                        mismatches = 0;
	int                        comparisons = 0;
	int                        seed = 2;
	int                        r;

	always #12.5 clk_i = ~clk_i;

	fmcc_host host (.clk_i(clk_i), .rdata_i(rdata), .sub_addr_o(sub_addr),
		.wr_en_o(wr_en), .rd_en_o(rd_en), .wdata_o(wdata));
	fmcc_config dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sub_addr_i(sub_addr),
		.wr_en_i(wr_en), .rd_en_i(rd_en), .wdata_i(wdata),
		.master_field_start_i(mfs), .slave_field_start_i(sfs),
		.rdata_o(rdata), .cfg_o(cfg));

	task automatic cmp(input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (e !== g) begin
			mismatches++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.put(a, d);
		if (a == 8'h53)
			sh[0] = d & 8'h03;
		if (a == 8'h58)
			sh[1] = d & 8'h0f;
		if (a == 8'h57)
			sh[2] = d & 8'h0f;
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] x;
		x = e;
		// Bit 7 of the operation byte: setup still waiting for a field
		if (a == 8'h53)
			x[7] = sh[0] != act[0] || sh[1] != act[1] ||
				sh[2] != act[2];
		host.get(a, rd);
		cmp(x, rd);
	endtask : rdchk
	function automatic logic [19:0] size(input logic [3:0] c);
		size[19:10] = c[3] ? 10'h300 : 10'h200;
		size[9:0] = c[3] ? (c[1] ? 10'h0aa : 10'h155)
			: (c[1] ? 10'h100 : 10'h200);
	endfunction : size
	task automatic chk();
		logic [3:0] m, s;
		logic       sc, mu, ns;
		logic [1:0] mf, sf;
		m  = act[1][3:0];
		s  = act[2][3:0];
		sc = act[0] == 8'h00 || act[0] == 8'h03;
		mu = act[0] == 8'h02;
		ns = ~sc;
		mf = m[1] ? (sc ? 2'h3 : 2'h2) : 2'h1;
		sf = s[1] ? (sc ? 2'h3 : 2'h2) : ((sc & m[1]) ? 2'h0 : 2'h1);
		cmp({sc, act[0] == 8'h01, mu}, {cfg.scan_rate_conversion_operation,
			cfg.split_screen_operation, cfg.multi_picture_operation});
		cmp({mf, sf}, {cfg.master_fields, cfg.slave_fields});
		cmp({mu & m[0], mu & s[0]}, {cfg.master_a_field_only_write,
			cfg.slave_a_field_only_write});
		cmp({sc & m[2], sc & s[2]}, {cfg.master_read_single_area,
			cfg.slave_read_insert_layout});
		cmp({ns & m[3], ns & s[3], sc & s[3]}, {cfg.master_width_768,
			cfg.slave_width_768, cfg.slave_write_dual_layout});
		if (ns)
			cmp({size(m), size(s)}, {cfg.master_max_pixels,
				cfg.master_max_lines, cfg.slave_max_pixels,
				cfg.slave_max_lines});
		else
			cmp({10'h300, s[1] ? 10'h120 : 10'h155,
				s[1] ? 20'h40068 : (m[1] ? 20'h00000 : 20'hc0155)},
				{cfg.master_max_pixels, cfg.master_max_lines,
				cfg.slave_max_pixels, cfg.slave_max_lines});
		cmp(ns & m[1] & s[1], cfg.double_window_config);
		if (act[0] == 8'h01)
			cmp(1'b0, cfg.vector_upconversion_allowed);
	endtask : chk
	task automatic apply(input logic m, input logic s);
		mfs <= m;
		sfs <= s;
		@(posedge clk_i);
		mfs <= 1'b0;
		sfs <= 1'b0;
		if (m) begin
			act[0] = sh[0];
			act[1] = sh[1];
		end
		if (s)
			act[2] = sh[2];
		// Decode lands two edges after the start is driven; two more for margin
		repeat (3) @(posedge clk_i);
		chk();
	endtask : apply
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	initial begin
		sh = '{8'h00, 8'h02, 8'h02};
		act = sh;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk();
		rdchk(8'h53, 8'h00);
		rdchk(8'h58, 8'h02);
		rdchk(8'h57, 8'h02);
		wr(8'h40, 8'hff);
		rdchk(8'h40, 8'h00);
		for (int i = 0; i < 7; i++) begin
			r = host.step(i);
			wr(8'h53, r[23:16]);
			wr(8'h58, r[15:8]);
			wr(8'h57, r[7:0]);
			chk();
			rdchk(8'h58, r[15:8]);
			rdchk(8'h53, r[23:16]);
			apply(1'b1, 1'b0);
			apply(1'b0, 1'b1);
		end
		for (int i = 0; i < 60; i++) begin
			r = $random(seed);
			wr(8'h53, r[7:0]);
			wr(8'h58, r[15:8]);
			wr(8'h57, r[23:16]);
			apply(r[24], r[25]);
			rdchk(8'h53, r[7:0] & 8'h03);
		end
		results();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		results();
	end
endmodule : test_fmcc_config
